// ===== src/rts_pkg.sv
// Functional notes
// - idle queue head always sent first
// - single: no control entry or credit, probe transit
// - single: control frame must fit primary space
// - passing control checks sends control head
// - primary transit head sent when entry present
// - single: primary empty, send client head
// - single: no client entry, nothing selected
// - wait for completion, then pick again
// - dual: primary class A, secondary B and C
// - each transit queue drained in FIFO order
// - secondary never overtakes earlier primary entries
// - control and class A traffic rate limited
// - dual: control frame must fit both queues
// - dual: primary head sent, else overflow guard
// - secondary under one MTU free gets drained
// - dual: no downstream credit or non-reserved skips client
// - dual: client head beats secondary queue unless secondary has under one MTU free
// - lowclass check sends secondary head if present
// - dual: hold until transmission completes
package rts_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register map, byte addresses on apb
  localparam logic [11:0] RTS_CTRL_OFS   = 12'h000;
  localparam logic [11:0] RTS_MTU_OFS    = 12'h004;
  localparam logic [11:0] RTS_STATUS_OFS = 12'h008;
  localparam logic [11:0] RTS_COUNT_OFS  = 12'h00c;

  // control register fields
  localparam int          RTS_CTRL_DUAL_BIT = 0;
  localparam int          RTS_CTRL_EN_BIT   = 1;
  localparam logic        RTS_DUAL_RST      = 1'b0;
  localparam logic        RTS_EN_RST        = 1'b1;

  // mtu register reset value in bytes
  localparam logic [15:0] RTS_MTU_RST = 16'h0600;

  // status register fields
  localparam int          RTS_STAT_STATE_LSB = 0;
  localparam int          RTS_STAT_SRC_LSB   = 8;

  ////////////////////////////////////////////////////////////////////////////
  // transmit sources, also index into the strobe vector
  localparam logic [2:0]  RTS_SRC_IDLE    = 3'h0;
  localparam logic [2:0]  RTS_SRC_CONTROL = 3'h1;
  localparam logic [2:0]  RTS_SRC_PRIMARY = 3'h2;
  localparam logic [2:0]  RTS_SRC_SECOND  = 3'h3;
  localparam logic [2:0]  RTS_SRC_CLIENT  = 3'h4;
  localparam logic [2:0]  RTS_SRC_NONE    = 3'h7;
  localparam int          RTS_NUM_SRC     = 5;

  // reserved class a subclass code on the client stage entry
  localparam logic [1:0]  RTS_RESERVED_SUBCLASS_CODE = 2'h0;

  // selection states, one-hot
  typedef enum logic [5:0] {
    RTS_PICK_START     = 6'h01,
    RTS_TRANSIT_PROBE  = 6'h02,
    RTS_OVERFLOW_GUARD = 6'h04,
    RTS_CLIENT_CHECK   = 6'h08,
    RTS_LOWCLASS_CHECK = 6'h10,
    RTS_WAIT_DONE      = 6'h20
  } rts_state_e;

endpackage

// ===== src/rts_fit_check.sv
`timescale 1ns/10ps
// size against free space comparison
module rts_fit_check
  import rts_pkg::*;
#(
  parameter int W = 16
) (
  input  wire logic [W-1:0] size_in,
  input  wire logic [W-1:0] free_in,
  output logic              fits_out
);

  // size that does not exceed the free space fits
  always_comb begin
    fits_out = (size_in <= free_in);
  end

endmodule

// ===== src/rts_send_strobe.sv
`timescale 1ns/10ps
// registered one-cycle dequeue strobe and last source record
module rts_send_strobe
  import rts_pkg::*;
(
  input  wire logic                   clk_in,
  input  wire logic                   rst_in,
  input  wire logic                   ce_in,
  input  wire logic                   fire_in,
  input  wire logic [2:0]             src_in,
  output logic      [RTS_NUM_SRC-1:0] strobe_out,
  output logic      [2:0]             last_src_out
);

  typedef struct packed {
    logic [RTS_NUM_SRC-1:0] strobe;
    logic [2:0]             last_src;
  } rts_strobe_s;

  rts_strobe_s st_q;
  rts_strobe_s st_d;

  // strobe lasts exactly one enabled cycle
  always_comb begin
    st_d        = st_q;
    st_d.strobe = '0;
    if (fire_in) begin
      st_d.strobe[src_in] = 1'b1;
      st_d.last_src       = src_in;
    end
  end

  // state register
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st_q <= '{strobe: '0, last_src: RTS_SRC_NONE};
    end else if (ce_in) begin
      st_q <= st_d;
    end
  end

  assign strobe_out   = st_q.strobe;
  assign last_src_out = st_q.last_src;

endmodule

// ===== src/rts_selector.sv
`timescale 1ns/10ps
// per-ringlet transmit frame selector with apb control
module rts_selector
  import rts_pkg::*;
#(
  parameter int BYTE_W   = 16,
  parameter int CREDIT_W = 8
) (
  input  wire logic                CLK_IN,
  input  wire logic                RST_IN,
  input  wire logic                CE_IN,
  // apb slave
  input  wire logic                PSEL_IN,
  input  wire logic                PENABLE_IN,
  input  wire logic                PWRITE_IN,
  input  wire logic [11:0]         PADDR_IN,
  input  wire logic [31:0]         PWDATA_IN,
  output logic      [31:0]         PRDATA_OUT,
  output logic                     PREADY_OUT,
  output logic                     PSLVERR_OUT,
  // queue status
  input  wire logic                IDLE_QUEUE_NONEMPTY_IN,
  input  wire logic                CONTROL_QUEUE_NONEMPTY_IN,
  input  wire logic                PRIMARY_QUEUE_NONEMPTY_IN,
  input  wire logic                SECONDARY_QUEUE_NONEMPTY_IN,
  input  wire logic                CLIENT_QUEUE_NONEMPTY_IN,
  input  wire logic [1:0]          CLIENT_SUBCLASS_IN,
  // shapers and sizes
  input  wire logic [CREDIT_W-1:0] CONTROL_SHAPER_CREDIT_IN,
  input  wire logic [CREDIT_W-1:0] DOWNSTREAM_SHAPER_CREDIT_IN,
  input  wire logic [BYTE_W-1:0]   CONTROL_FRAME_BYTES_IN,
  input  wire logic [BYTE_W-1:0]   PRIMARY_FREE_BYTES_IN,
  input  wire logic [BYTE_W-1:0]   SECONDARY_FREE_BYTES_IN,
  // transmit path
  input  wire logic                TX_DONE_IN,
  output logic                     SEND_IDLE_HEAD_OUT,
  output logic                     SEND_CONTROL_HEAD_OUT,
  output logic                     SEND_PRIMARY_HEAD_OUT,
  output logic                     SEND_SECONDARY_HEAD_OUT,
  output logic                     SEND_CLIENT_HEAD_OUT,
  output logic      [2:0]          TX_SOURCE_OUT,
  output logic                     BUSY_OUT
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  // selection state, control bits and the registered bus answer
  typedef struct packed {
    rts_state_e  state;
    logic        dual_mode;
    logic        enable;
    logic [15:0] mtu;
    logic [31:0] sent_count;
    logic [31:0] rdata;
    logic        slverr;
  } rts_main_s;

  rts_main_s st_q;
  rts_main_s st_d;

  // send request of this cycle and the source it names
  logic                   fire;
  logic [2:0]             fire_src;
  logic [RTS_NUM_SRC-1:0] strobes;
  logic [2:0]             last_src;
  logic                   ctrl_fits_primary;
  logic                   ctrl_fits_second;
  logic                   second_has_mtu;
  logic [BYTE_W-1:0]      mtu_bytes;
  logic                   apb_access;
  logic                   apb_write;
  logic                   addr_ok;
  logic                   no_ctrl_credit;
  logic                   client_skip;
  logic [31:0]            status_word;

  ////////////////////////////////////////////////////////////////////////////
  // space checks

  assign mtu_bytes = BYTE_W'(st_q.mtu);

  // control frame against primary free space
  rts_fit_check #(
    .W (BYTE_W)
  ) u_fit_primary (
    .size_in  (CONTROL_FRAME_BYTES_IN),
    .free_in  (PRIMARY_FREE_BYTES_IN),
    .fits_out (ctrl_fits_primary)
  );

  // control frame against secondary free space
  rts_fit_check #(
    .W (BYTE_W)
  ) u_fit_second (
    .size_in  (CONTROL_FRAME_BYTES_IN),
    .free_in  (SECONDARY_FREE_BYTES_IN),
    .fits_out (ctrl_fits_second)
  );

  // at least one mtu still free in the secondary queue
  rts_fit_check #(
    .W (BYTE_W)
  ) u_fit_mtu (
    .size_in  (mtu_bytes),
    .free_in  (SECONDARY_FREE_BYTES_IN),
    .fits_out (second_has_mtu)
  );

  ////////////////////////////////////////////////////////////////////////////
  // bus decode

  // pready is tied high, so an access phase never stretches
  assign apb_access = PSEL_IN && PENABLE_IN;
  assign apb_write  = apb_access && PWRITE_IN;

  // mapped offsets
  always_comb begin
    case (PADDR_IN)
      RTS_CTRL_OFS:   addr_ok = 1'b1;
      RTS_MTU_OFS:    addr_ok = 1'b1;
      RTS_STATUS_OFS: addr_ok = 1'b1;
      RTS_COUNT_OFS:  addr_ok = 1'b1;
      default:        addr_ok = 1'b0;
    endcase
  end

  // live status word
  always_comb begin
    status_word = '0;
    status_word[RTS_STAT_STATE_LSB +: 6] = st_q.state;
    status_word[RTS_STAT_SRC_LSB +: 3]   = last_src;
  end

  // shaper credit and downstream permit terms
  // zero credit on a shaper means that source has to wait; downstream credit gates the client in dual mode only
  assign no_ctrl_credit = (CONTROL_SHAPER_CREDIT_IN == '0);
  assign client_skip    = (DOWNSTREAM_SHAPER_CREDIT_IN == '0)
                       || (CLIENT_QUEUE_NONEMPTY_IN
                           && (CLIENT_SUBCLASS_IN != RTS_RESERVED_SUBCLASS_CODE));

  ////////////////////////////////////////////////////////////////////////////
  // next state: selection machine and register file

  // one state is evaluated per enabled cycle; queue levels are
  // sampled afresh in every state, so an entry that arrives late
  // in a pass is still seen by the later checks of that pass
  always_comb begin
    st_d     = st_q;
    fire     = 1'b0;
    fire_src = RTS_SRC_NONE;

    case (st_q.state)
      // idle frames first, then control frames that pass every gate
      RTS_PICK_START: begin
        if (!st_q.enable) begin
          st_d.state = RTS_PICK_START;
        end else if (IDLE_QUEUE_NONEMPTY_IN) begin
          fire       = 1'b1;
          fire_src   = RTS_SRC_IDLE;
          st_d.state = RTS_WAIT_DONE;
        end else if (!CONTROL_QUEUE_NONEMPTY_IN || no_ctrl_credit) begin
          st_d.state = RTS_TRANSIT_PROBE;
        end else if (!ctrl_fits_primary) begin
          st_d.state = RTS_TRANSIT_PROBE;
        end else if (st_q.dual_mode && !ctrl_fits_second) begin
          st_d.state = RTS_TRANSIT_PROBE;
        end else begin
          fire       = 1'b1;
          fire_src   = RTS_SRC_CONTROL;
          st_d.state = RTS_WAIT_DONE;
        end
      end

      // primary transit entries beat everything but idle and control
      RTS_TRANSIT_PROBE: begin
        if (PRIMARY_QUEUE_NONEMPTY_IN) begin
          fire       = 1'b1;
          fire_src   = RTS_SRC_PRIMARY;
          st_d.state = RTS_WAIT_DONE;
        end else if (st_q.dual_mode) begin
          st_d.state = RTS_OVERFLOW_GUARD;
        end else begin
          st_d.state = RTS_CLIENT_CHECK;
        end
      end

      // secondary is only reached once primary was seen empty
      RTS_OVERFLOW_GUARD: begin
        if (!second_has_mtu && SECONDARY_QUEUE_NONEMPTY_IN) begin
          fire       = 1'b1;
          fire_src   = RTS_SRC_SECOND;
          st_d.state = RTS_WAIT_DONE;
        end else begin
          st_d.state = RTS_CLIENT_CHECK;
        end
      end

      // single mode ends the pass here; dual mode still tries secondary
      RTS_CLIENT_CHECK: begin
        if (st_q.dual_mode) begin
          if (client_skip) begin
            st_d.state = RTS_LOWCLASS_CHECK;
          end else if (CLIENT_QUEUE_NONEMPTY_IN) begin
            fire       = 1'b1;
            fire_src   = RTS_SRC_CLIENT;
            st_d.state = RTS_WAIT_DONE;
          end else begin
            st_d.state = RTS_LOWCLASS_CHECK;
          end
        end else if (CLIENT_QUEUE_NONEMPTY_IN) begin
          fire       = 1'b1;
          fire_src   = RTS_SRC_CLIENT;
          st_d.state = RTS_WAIT_DONE;
        end else begin
          st_d.state = RTS_PICK_START;
        end
      end

      // last chance of a dual pass; an empty pass starts over
      RTS_LOWCLASS_CHECK: begin
        if (SECONDARY_QUEUE_NONEMPTY_IN) begin
          fire       = 1'b1;
          fire_src   = RTS_SRC_SECOND;
          st_d.state = RTS_WAIT_DONE;
        end else begin
          st_d.state = RTS_PICK_START;
        end
      end

      // hold the chosen transfer until the path reports completion
      RTS_WAIT_DONE: begin
        if (TX_DONE_IN) begin
          st_d.state = RTS_PICK_START;
        end
      end

      default: begin
        st_d.state = RTS_PICK_START;
      end
    endcase

    // frames sent since reset
    if (fire) begin
      st_d.sent_count = st_q.sent_count + 32'h0000_0001;
    end

    // register writes; enable acts at the next pick, mode from the next cycle in any state
    // status and count are read only, writes there are dropped
    if (apb_write) begin
      case (PADDR_IN)
        RTS_CTRL_OFS: begin
          st_d.dual_mode = PWDATA_IN[RTS_CTRL_DUAL_BIT];
          st_d.enable    = PWDATA_IN[RTS_CTRL_EN_BIT];
        end
        RTS_MTU_OFS: begin
          st_d.mtu = PWDATA_IN[15:0];
        end
        default: begin
          st_d.mtu = st_d.mtu;
        end
      endcase
    end

    // read data and error registered in the setup cycle
    // unmapped offsets read as zero and raise the error flag
    st_d.slverr = PSEL_IN && !PENABLE_IN && !addr_ok;
    if (PSEL_IN && !PENABLE_IN && !PWRITE_IN) begin
      case (PADDR_IN)
        RTS_CTRL_OFS: begin
          st_d.rdata = '0;
          st_d.rdata[RTS_CTRL_DUAL_BIT] = st_q.dual_mode;
          st_d.rdata[RTS_CTRL_EN_BIT]   = st_q.enable;
        end
        RTS_MTU_OFS:    st_d.rdata = {16'h0000, st_q.mtu};
        RTS_STATUS_OFS: st_d.rdata = status_word;
        RTS_COUNT_OFS:  st_d.rdata = st_q.sent_count;
        default:        st_d.rdata = '0;
      endcase
    end else if (!PSEL_IN) begin
      st_d.rdata = '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  // clock enable low freezes selection, bus registers and strobes alike
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      st_q <= '{state:      RTS_PICK_START,
                dual_mode:  RTS_DUAL_RST,
                enable:     RTS_EN_RST,
                mtu:        RTS_MTU_RST,
                sent_count: 32'h0000_0000,
                rdata:      32'h0000_0000,
                slverr:     1'b0};
    end else if (CE_IN) begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // dequeue strobes

  // one strobe per send, first cycle of wait_done
  rts_send_strobe u_strobe (
    .clk_in       (CLK_IN),
    .rst_in       (RST_IN),
    .ce_in        (CE_IN),
    .fire_in      (fire),
    .src_in       (fire_src),
    .strobe_out   (strobes),
    .last_src_out (last_src)
  );

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  // strobes and source come straight from flops of the strobe stage
  assign SEND_IDLE_HEAD_OUT      = strobes[RTS_SRC_IDLE];
  assign SEND_CONTROL_HEAD_OUT   = strobes[RTS_SRC_CONTROL];
  assign SEND_PRIMARY_HEAD_OUT   = strobes[RTS_SRC_PRIMARY];
  assign SEND_SECONDARY_HEAD_OUT = strobes[RTS_SRC_SECOND];
  assign SEND_CLIENT_HEAD_OUT    = strobes[RTS_SRC_CLIENT];
  assign TX_SOURCE_OUT           = last_src;
  assign BUSY_OUT                = (st_q.state == RTS_WAIT_DONE);
  assign PRDATA_OUT              = st_q.rdata;
  assign PREADY_OUT              = 1'b1; // no wait states
  assign PSLVERR_OUT             = st_q.slverr && apb_access;

endmodule

// ===== tb/rts_tx_path.sv
`timescale 1ns/10ps
// ringlet transmit path: takes a dequeued frame, reports completion later
module rts_tx_path (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       start_in,
  input  wire logic [3:0] delay_in,
  output logic            done_out
);
  logic [3:0] left_q;
  logic       run_q;
  // frame time counter, completion is a single pulse
  always_ff @(posedge clk_in) begin
    done_out <= 1'b0;
    if (rst_in) begin
      run_q  <= 1'b0;
      left_q <= 4'h0;
    end else if (start_in) begin
      run_q  <= 1'b1;
      left_q <= delay_in;
    end else if (run_q && left_q == 4'h0) begin
      run_q    <= 1'b0;
      done_out <= 1'b1;
    end else if (run_q) begin
      left_q <= left_q - 4'h1;
    end
  end
endmodule

// ===== tb/rts_selector_properties.sv
`timescale 1ns/10ps
// port-level checks of the transmit selector
module rts_selector_properties
  import rts_pkg::*;
#(
  parameter int CREDIT_W = 8
) (
  input wire logic                CLK_IN,
  input wire logic                RST_IN,
  input wire logic                IDLE_QUEUE_NONEMPTY_IN,
  input wire logic                CONTROL_QUEUE_NONEMPTY_IN,
  input wire logic                PRIMARY_QUEUE_NONEMPTY_IN,
  input wire logic                SECONDARY_QUEUE_NONEMPTY_IN,
  input wire logic [CREDIT_W-1:0] CONTROL_SHAPER_CREDIT_IN,
  input wire logic                TX_DONE_IN,
  input wire logic                SEND_IDLE_HEAD_OUT,
  input wire logic                SEND_CONTROL_HEAD_OUT,
  input wire logic                SEND_PRIMARY_HEAD_OUT,
  input wire logic                SEND_SECONDARY_HEAD_OUT,
  input wire logic                SEND_CLIENT_HEAD_OUT,
  input wire logic [2:0]          TX_SOURCE_OUT,
  input wire logic                BUSY_OUT
);
  logic [4:0] sends;
  // strobes gathered, bit index is the source code
  assign sends = {SEND_CLIENT_HEAD_OUT, SEND_SECONDARY_HEAD_OUT, SEND_PRIMARY_HEAD_OUT,
                  SEND_CONTROL_HEAD_OUT, SEND_IDLE_HEAD_OUT};
  default clocking dc @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);
  //////////////////////////////////////////////////////////////////
  a_one_source: assert property ($onehot0(sends))
    else $error("two strobes at once");
  a_strobe_pulse: assert property (|sends |=> sends == 5'h0)
    else $error("strobe too long");
  a_send_busy: assert property (|sends |-> BUSY_OUT)
    else $error("send without wait");
  a_busy_cause: assert property ($rose(BUSY_OUT) |-> |sends)
    else $error("wait without send");
  a_wait_hold: assert property (BUSY_OUT && !TX_DONE_IN |=> BUSY_OUT)
    else $error("wait left early");
  a_done_release: assert property (BUSY_OUT && TX_DONE_IN |=> !BUSY_OUT)
    else $error("wait kept after done");
  a_idle_cause: assert property (SEND_IDLE_HEAD_OUT |-> $past(IDLE_QUEUE_NONEMPTY_IN))
    else $error("idle sent while empty");
  a_control_gate: assert property (SEND_CONTROL_HEAD_OUT |-> !$past(IDLE_QUEUE_NONEMPTY_IN) &&
    $past(CONTROL_QUEUE_NONEMPTY_IN) && $past(CONTROL_SHAPER_CREDIT_IN) != 0)
    else $error("control sent against gate");
  a_primary_cause: assert property (SEND_PRIMARY_HEAD_OUT |-> $past(PRIMARY_QUEUE_NONEMPTY_IN))
    else $error("primary sent while empty");
  a_cross_order: assert property (SEND_SECONDARY_HEAD_OUT |->
    $past(SECONDARY_QUEUE_NONEMPTY_IN) && !$past(PRIMARY_QUEUE_NONEMPTY_IN))
    else $error("secondary overtook primary");
  a_source_code: assert property (|sends |-> sends == (5'h1 << TX_SOURCE_OUT))
    else $error("source code mismatch");
  c_idle: cover property (SEND_IDLE_HEAD_OUT);
  c_control: cover property (SEND_CONTROL_HEAD_OUT);
  c_second: cover property (SEND_SECONDARY_HEAD_OUT);
  c_client: cover property (SEND_CLIENT_HEAD_OUT);
endmodule

bind rts_selector rts_selector_properties #(.CREDIT_W(CREDIT_W)) i_rts_selector_properties (
  .CLK_IN(CLK_IN), .RST_IN(RST_IN), .TX_DONE_IN(TX_DONE_IN),
  .IDLE_QUEUE_NONEMPTY_IN(IDLE_QUEUE_NONEMPTY_IN), .CONTROL_QUEUE_NONEMPTY_IN(CONTROL_QUEUE_NONEMPTY_IN),
  .PRIMARY_QUEUE_NONEMPTY_IN(PRIMARY_QUEUE_NONEMPTY_IN), .SECONDARY_QUEUE_NONEMPTY_IN(SECONDARY_QUEUE_NONEMPTY_IN),
  .CONTROL_SHAPER_CREDIT_IN(CONTROL_SHAPER_CREDIT_IN), .SEND_IDLE_HEAD_OUT(SEND_IDLE_HEAD_OUT),
  .SEND_CONTROL_HEAD_OUT(SEND_CONTROL_HEAD_OUT), .SEND_PRIMARY_HEAD_OUT(SEND_PRIMARY_HEAD_OUT),
  .SEND_SECONDARY_HEAD_OUT(SEND_SECONDARY_HEAD_OUT), .SEND_CLIENT_HEAD_OUT(SEND_CLIENT_HEAD_OUT),
  .TX_SOURCE_OUT(TX_SOURCE_OUT), .BUSY_OUT(BUSY_OUT)
);

// ===== tb/rts_selector_bench.sv
`timescale 1ns/10ps
// self-checking bench for the transmit selector
module rts_selector_bench
  import rts_pkg::*;
;
  logic        clk, rst, psel, penable, pwrite, pready, pslverr, tx_done, busy, dual, e, ce;
  logic        idle_ne, ctl_ne, pri_ne, sec_ne, cli_ne;
  logic [1:0]  sub;
  logic [7:0]  ccred, dcred;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [15:0] cbytes, pfree, sfree, mtu;
  logic [4:0]  snd, acc;
  logic [2:0]  tx_src;
  logic [3:0]  delay;
  int          miscompares = 0;
  int          checks = 0;
  int          sent = 0;
  int          lx = 7;

  rts_selector i_rts_selector (
    .CLK_IN(clk), .RST_IN(rst), .CE_IN(ce), .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite),
    .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
    .IDLE_QUEUE_NONEMPTY_IN(idle_ne), .CONTROL_QUEUE_NONEMPTY_IN(ctl_ne), .PRIMARY_QUEUE_NONEMPTY_IN(pri_ne),
    .SECONDARY_QUEUE_NONEMPTY_IN(sec_ne), .CLIENT_QUEUE_NONEMPTY_IN(cli_ne), .CLIENT_SUBCLASS_IN(sub),
    .CONTROL_SHAPER_CREDIT_IN(ccred), .DOWNSTREAM_SHAPER_CREDIT_IN(dcred), .CONTROL_FRAME_BYTES_IN(cbytes),
    .PRIMARY_FREE_BYTES_IN(pfree), .SECONDARY_FREE_BYTES_IN(sfree), .TX_DONE_IN(tx_done),
    .SEND_IDLE_HEAD_OUT(snd[0]), .SEND_CONTROL_HEAD_OUT(snd[1]), .SEND_PRIMARY_HEAD_OUT(snd[2]),
    .SEND_SECONDARY_HEAD_OUT(snd[3]), .SEND_CLIENT_HEAD_OUT(snd[4]), .TX_SOURCE_OUT(tx_src), .BUSY_OUT(busy)
  );

  rts_tx_path i_rts_tx_path (
    .clk_in(clk), .rst_in(rst), .start_in(|snd), .delay_in(delay), .done_out(tx_done)
  );

  //////////////////////////////////////////////////////////////////
  task automatic conclude();
    if (miscompares == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // one apb transfer: setup, then access until pready
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      miscompares++;
      conclude();
    end
  endtask

  // reference choice of source, 7 when nothing can go
  function automatic int pick();
    if (idle_ne) return 0;
    if (ctl_ne && ccred != 0 && cbytes <= pfree && (!dual || cbytes <= sfree)) return 1;
    if (pri_ne) return 2;
    if (!dual) return cli_ne ? 4 : 7;
    if (sec_ne && sfree < mtu) return 3;
    if (dcred != 0 && cli_ne && sub == RTS_RESERVED_SUBCLASS_CODE) return 4;
    return sec_ne ? 3 : 7;
  endfunction

  task automatic grab(output logic [4:0] s);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (snd === 5'h0 && n < 20);
    s = snd;
  endtask

  // one selection pass against the reference
  task automatic run();
    int         x;
    logic [4:0] s;
    #1 x = pick();
    grab(s);
    if (x == 7) begin
      chk("empty pass", 32'h0, 32'(s));
      idle_ne <= 1'b1;
      x = 0;
      grab(s);
    end
    chk("strobe", 32'h1 << x, 32'(s));
    chk("source", 32'(x), 32'(tx_src));
    if (s === 5'h0) conclude();
    lx = x;
    sent++;
    delay <= 4'($urandom % 8);
  endtask

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // reset, register checks, then both selection variants
  initial begin
    rst = 1'b1;
    {psel, penable, pwrite, idle_ne, ctl_ne, pri_ne, sec_ne, cli_ne, dual} = 9'h0;
    ce = 1'b1;
    {paddr, pwdata, sub, ccred, dcred, cbytes, pfree, sfree, delay} = 0;
    mtu = 16'h05f0;
    void'($urandom(95));
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, RTS_CTRL_OFS, 32'h0);
    chk("ctrl", {30'h0, RTS_EN_RST, RTS_DUAL_RST}, r);
    chk("reset source", 32'(RTS_SRC_NONE), 32'(tx_src));
    apb(1'b0, RTS_MTU_OFS, 32'h0);
    chk("mtu", {16'h0, RTS_MTU_RST}, r);
    apb(1'b1, RTS_MTU_OFS, {16'h0, mtu});
    apb(1'b0, RTS_MTU_OFS, 32'h0);
    chk("mtu write", {16'h0, mtu}, r);
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped err", 32'h1, 32'(e));
    // frozen clock enable, then a disabled selector: no send either way
    for (int k = 0; k < 2; k++) begin
      ce <= 1'(k);
      if (k == 1) apb(1'b1, RTS_CTRL_OFS, 32'h0);
      idle_ne <= 1'b1;
      acc = 5'h0;
      repeat (8) begin
        @(posedge clk);
        acc = acc | snd;
      end
      chk("held strobe", 32'h0, 32'(acc));
      idle_ne <= 1'b0;
    end
    for (int m = 0; m < 2; m++) begin
      {idle_ne, ctl_ne, pri_ne, sec_ne, cli_ne} <= 5'h0;
      apb(1'b1, RTS_CTRL_OFS, 32'h2 | 32'(m));
      dual = 1'(m);
      idle_ne <= 1'b1;
      run();
      repeat (60) begin
        {ctl_ne, pri_ne, sec_ne, cli_ne, sub} <= 6'($urandom);
        idle_ne <= ($urandom % 5) == 0;
        ccred   <= 8'($urandom % 3);
        dcred   <= 8'($urandom % 3);
        cbytes  <= 16'h05e8 + 16'($urandom % 32);
        pfree   <= 16'h05e8 + 16'($urandom % 32);
        sfree   <= 16'h05e8 + 16'($urandom % 32);
        run();
      end
    end
    {idle_ne, ctl_ne, pri_ne, sec_ne, cli_ne} <= 5'h0;
    apb(1'b0, RTS_COUNT_OFS, 32'h0);
    chk("count", 32'(sent), r);
    apb(1'b0, RTS_STATUS_OFS, 32'h0);
    chk("status source", 32'(lx), 32'(r[RTS_STAT_SRC_LSB +: 3]));
    conclude();
  end
endmodule
